// ==== sdf_pkg.sv ====
package sdf_pkg;

  // ==========================================================================
  // Register map and fields.
  // ==========================================================================
  localparam logic [11:0] SDF_THREAD_SWITCH_CONTROL_REG_OFS = 12'h000;
  localparam logic [11:0] SDF_MODE_OFS = 12'h004;
  localparam logic [11:0] SDF_STATUS_OFS = 12'h008;
  localparam logic [11:0] SDF_MISS_CNT_OFS = 12'h00C;
  localparam int SDF_BAL_DIS_BIT = 2;
  localparam int SDF_BAL_DISP_BIT = 3;
  localparam int SDF_THR_LSB = 8;
  localparam int SDF_DBG_EXCL_BIT = 16;
  localparam logic [31:0] SDF_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SDF_MODE_RST = 32'h0000_0000;

  // ==========================================================================
  // Timing counts.
  // ==========================================================================
  localparam int SDF_COUNT_LAT = 5;
  localparam int SDF_STALL_LAT = 4;
  localparam int SDF_CNT_W = 4;

  // Thread modes.
  typedef enum logic [2:0] {
    SDF_SINGLE = 3'b001,
    SDF_TWO_THREAD_MODE = 3'b010,
    SDF_FOUR_THREAD_MODE = 3'b100
  } sdf_mode_t;

  // Per-thread decode-side request bundle.
  typedef struct packed {
    logic ptesync;
    logic tlb_inval;
    logic after_inval;
    logic scoreboard;
    logic serialize;
    logic in_ucode;
  } sdf_decode_t;

  // Per-thread resource stall causes.
  typedef struct packed {
    logic no_rsv_entry;
    logic no_hist_buf;
    logic table_full;
  } sdf_stall_t;

endpackage : sdf_pkg

// ==== sdf_flow_control.sv ====
`timescale 1ns/1ns
module sdf_flow_control
  import sdf_pkg::*;
#(
  parameter int NTHR = 4,
  parameter int CW = 6
) (
  input wire logic core_clk,
  input wire logic nrst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Per-thread core side.
  input wire logic [NTHR-1:0] thread_active,
  input wire logic [NTHR-1:0] dispatch_set,
  input wire sdf_decode_t [NTHR-1:0] decode_req,
  input wire sdf_stall_t [NTHR-1:0] stall_cause,
  input wire logic [NTHR-1:0][CW-1:0] completion_count,
  input wire logic [NTHR-1:0] inval_ack,
  input wire logic [NTHR-1:0] store_reorder_queue_empty,
  input wire logic [NTHR-1:0] ptesync_ready,
  input wire logic [NTHR-1:0] miss_pending,
  input wire logic [NTHR-1:0] miss_resolved,
  input wire logic dispatch_buffer_empty,
  input wire logic [NTHR-1:0] decode_request,
  output logic [NTHR-1:0] dispatch_flush,
  output logic [NTHR-1:0] balance_flush,
  output logic [NTHR-1:0] dispatch_hold,
  output logic [NTHR-1:0] decode_hold,
  output logic [NTHR-1:0] completion_based_hold,
  output logic [NTHR-1:0] decode_eligible
);

  // The block keeps no instruction data. It only
  // decides which thread to flush or hold, and
  // when, from levels sampled at each clock edge.
  // Flush outputs are registered. balance_flush is
  // a one-cycle pulse; dispatch_flush stays high
  // while its cause lasts.
  // The stall hold and decode eligibility are
  // combinational, so the decode arbiter sees them
  // in the same cycle as their cause.
  // Output summary, one bit per thread:
  // dispatch_flush drops the thread's decode pipe.
  // balance_flush drops work younger than the
  // group that is next to complete.
  // dispatch_hold stops decode on a resource stall.
  // decode_hold keeps the thread at its buffer.
  // completion_based_hold follows a balance flush.
  // decode_eligible names threads decode may pick.
  // Only four threads are served; the mode decode
  // and the active-thread sums rely on it.
  initial begin
    if (NTHR != 4 || CW < 1) begin
      $error("sdf_flow_control: NTHR must be 4 and CW at least 1.");
    end
  end

  // ==========================================================================
  // Reset release.
  // ==========================================================================
  logic rst_s1;
  logic rst_n;
  // Reset takes effect at once but is released
  // only after two clean edges, so no flip-flop
  // leaves reset inside a setup window. All other
  // logic resets from the released copy.

  // Two-stage release of the asynchronous reset.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ==========================================================================
  // APB registers.
  // ==========================================================================
  // The control word holds the balance disable,
  // the balance dispatch enable, the two-bit miss
  // threshold code and the debug exclusion. Only
  // two bits of the mode word are kept. Status and
  // counter words are read-only.
  logic [31:0] thread_switch_control_reg;
  logic [31:0] mode_reg;
  logic [NTHR-1:0][SDF_CNT_W-1:0] miss_cnt;
  logic [NTHR-1:0] pt_hold;
  logic [NTHR-1:0] inv_hold;
  logic [NTHR-1:0] next_hold;
  logic [NTHR-1:0] miss_hold;

  wire logic wr_en = psel && penable && pwrite;
  wire logic sel_ctrl = paddr == SDF_THREAD_SWITCH_CONTROL_REG_OFS;
  wire logic sel_mode = paddr == SDF_MODE_OFS;
  wire logic sel_stat = paddr == SDF_STATUS_OFS;
  wire logic sel_cnt = paddr == SDF_MISS_CNT_OFS;
  wire logic mapped = sel_ctrl || sel_mode || sel_stat || sel_cnt;
  wire logic bal_disable = thread_switch_control_reg[SDF_BAL_DIS_BIT];
  wire logic bal_disp_en = thread_switch_control_reg[SDF_BAL_DISP_BIT];
  wire logic dbg_excl = thread_switch_control_reg[SDF_DBG_EXCL_BIT];
  wire logic [1:0] thr_code = thread_switch_control_reg[SDF_THR_LSB+1:SDF_THR_LSB];
  // Threshold of 2, 4, 8 or 15 misses from the two-bit field.
  // Code three stops at fifteen, the top count.
  wire logic [SDF_CNT_W-1:0] threshold = (thr_code == 2'h3) ? 4'hF : 4'(4'h2 << thr_code);
  // Mode code three is undefined and acts as
  // single-thread operation.
  wire sdf_mode_t mode = (mode_reg[1:0] == 2'h1) ? SDF_TWO_THREAD_MODE :
                         (mode_reg[1:0] == 2'h2) ? SDF_FOUR_THREAD_MODE : SDF_SINGLE;
  wire logic [31:0] status_word = {16'h0000, miss_hold, next_hold, inv_hold, pt_hold};
  wire logic [31:0] cnt_word = {16'h0000, miss_cnt};

  // The slave never waits: every access ends in
  // its first access cycle. An unmapped offset
  // answers with an error, drops write data and
  // reads zero. Both handshake outputs are plain
  // decodes.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Register writes take effect in the access phase.
  // That edge is the only one at which the master
  // holds select, enable and write data together.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      thread_switch_control_reg <= SDF_CTRL_RST;
      mode_reg <= SDF_MODE_RST;
    end else if (wr_en && sel_ctrl) begin
      thread_switch_control_reg <= pwdata;
    end else if (wr_en && sel_mode) begin
      mode_reg <= {30'h0, pwdata[1:0]};
    end
  end

  // Read data is registered in the setup cycle.
  // The word then stands through the access phase
  // and is taken at the edge that ends it.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= sel_ctrl ? thread_switch_control_reg : sel_mode ? mode_reg :
                sel_stat ? status_word : sel_cnt ? cnt_word : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Thread-level qualifiers.
  // ==========================================================================
  // Dispatch flushes need a multithreaded mode and
  // more than one active thread. Three bits count
  // up to the four threads served here.
  logic [2:0] nact;
  logic multi;
  always_comb begin
    nact = 3'h0;
    for (int i = 0; i < NTHR; i++) begin
      nact = nact + {2'h0, thread_active[i]};
    end
    multi = (mode != SDF_SINGLE) && (nact > 3'h1);
  end

  // Completion count pipeline: the count is acted on five cycles later.
  logic [SDF_COUNT_LAT-1:0][NTHR-1:0] cnz_pipe;
  logic [NTHR-1:0] cnz;
  // The late count feeds balance selection only,
  // so a thread that has only just gained entries
  // is not chosen. Invalidate decisions use the
  // current count, as they order one instruction.
  // The delay line resets empty, so no thread
  // looks busy right after reset.
  always_comb begin
    for (int i = 0; i < NTHR; i++) begin
      cnz[i] = completion_count[i] != '0;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnz_pipe <= '0;
    end else begin
      cnz_pipe <= {cnz_pipe[SDF_COUNT_LAT-2:0], cnz};
    end
  end
  wire logic [NTHR-1:0] has_entries = cnz_pipe[SDF_COUNT_LAT-1];

  // Stall detection and its four-cycle path to the flush.
  logic [NTHR-1:0] stalled;
  logic [SDF_STALL_LAT-1:0][NTHR-1:0] stall_pipe;
  always_comb begin
    for (int i = 0; i < NTHR; i++) begin
      stalled[i] = thread_active[i] && (stall_cause[i] != '0);
    end
  end
  // The stall hold is combinational so decode
  // stops in the cycle a resource runs out; it is
  // forced low while reset is held. Only active
  // threads count, so an idle thread may show
  // stale causes. The delayed copy gates only the
  // balance-driven dispatch flush.
  assign dispatch_hold = stalled & {NTHR{rst_n}};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_pipe <= '0;
    end else begin
      stall_pipe <= {stall_pipe[SDF_STALL_LAT-2:0], stalled};
    end
  end
  wire logic [NTHR-1:0] stall_late = stall_pipe[SDF_STALL_LAT-1];

  // ==========================================================================
  // Balance flush selection.
  // ==========================================================================
  // A candidate has a miss outstanding, is active,
  // owns a completion entry and is not already
  // held for an earlier balance flush, so one miss
  // cannot flush a thread every cycle. Selection
  // runs only while a thread stalls or the
  // dispatch buffer is empty. One candidate is
  // always flushed; several only in four-thread
  // mode, as flushing both in two-thread mode
  // would leave no thread to run.
  logic [NTHR-1:0] elig;
  logic [NTHR-1:0] bal_sel;
  logic [2:0] nelig;
  logic any_stall;
  always_comb begin
    any_stall = |stalled;
    nelig = 3'h0;
    for (int i = 0; i < NTHR; i++) begin
      elig[i] = miss_pending[i] && thread_active[i] && has_entries[i]
                && (!dbg_excl || miss_cnt[i] < threshold) && !miss_hold[i];
      nelig = nelig + {2'h0, elig[i]};
    end
    bal_sel = '0;
    if (multi && !bal_disable && (any_stall || dispatch_buffer_empty)) begin
      if (nelig == 3'h1) begin
        bal_sel = elig;
      end else if (mode == SDF_FOUR_THREAD_MODE) begin
        bal_sel = elig;
      end else begin
        bal_sel = '0;
      end
    end
  end

  // ==========================================================================
  // Dispatch flush decision.
  // ==========================================================================
  // Two active threads with the same group number
  // share; both left in group zero counts too. A
  // thread that does not run is never flushed.
  // Sync, scoreboard and serializing causes flush
  // even inside microcode, being needed for
  // correctness; only the balance-driven flush,
  // made for performance, waits for microcode.
  logic [NTHR-1:0] shares;
  logic [NTHR-1:0] next_dflush;
  always_comb begin
    for (int i = 0; i < NTHR; i++) begin
      // Partner thread in the same dispatch set; both in set zero included.
      shares[i] = 1'b0;
      for (int j = 0; j < NTHR; j++) begin
        if (j != i && thread_active[i] && thread_active[j] && dispatch_set[j] == dispatch_set[i]) begin
          shares[i] = 1'b1;
        end
      end
      next_dflush[i] = 1'b0;
      if (multi && shares[i]) begin
        if (decode_req[i].ptesync || decode_req[i].scoreboard
            || decode_req[i].serialize) begin
          next_dflush[i] = 1'b1;
        end
        if (decode_req[i].tlb_inval && cnz[i]) begin
          next_dflush[i] = 1'b1;
        end
        if (decode_req[i].after_inval && !inval_ack[i]) begin
          next_dflush[i] = 1'b1;
        end
        if (!decode_req[i].in_ucode && bal_disp_en && bal_sel[i] && stall_late[i]) begin
          next_dflush[i] = 1'b1;
        end
      end
    end
  end

  // Flush outputs are registered; balance_flush is a
  // one-cycle pulse, dispatch_flush stays high for
  // as long as its cause lasts.
  // Each follows its cause by one clock. The
  // balance pulse asks the execution units, the
  // completion table and the address table to drop
  // all work younger than next-to-complete.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dispatch_flush <= '0;
      balance_flush <= '0;
    end else begin
      dispatch_flush <= next_dflush;
      balance_flush <= bal_sel;
    end
  end

  // ==========================================================================
  // Decode holds and miss counters.
  // ==========================================================================
  // Each thread has four decode holds and a miss
  // counter. A hold is set in the cycle of its
  // flush, so decode never meets the flushed
  // instruction before the hold is in place. A set
  // and a release in one cycle: the set wins. The
  // status word shows every hold to software.
  // The counter clears only on a resolved miss.
  genvar t;
  generate
    for (t = 0; t < NTHR; t++) begin : g_thr
      wire logic mhold_end = miss_resolved[t] || miss_cnt[t] >= threshold;
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          pt_hold[t] <= 1'b0;
          inv_hold[t] <= 1'b0;
          next_hold[t] <= 1'b0;
          miss_hold[t] <= 1'b0;
          miss_cnt[t] <= '0;
        end else begin
          // Page-table sync held after its flush until ready.
          // It waits for its own conditions, not priority.
          if (next_dflush[t] && decode_req[t].ptesync) begin
            pt_hold[t] <= 1'b1;
          end else if (ptesync_ready[t]) begin
            pt_hold[t] <= 1'b0;
          end
          // Invalidate held until this thread's completion entries drain.
          // Only then is no older work left on it.
          if (next_dflush[t] && decode_req[t].tlb_inval) begin
            inv_hold[t] <= 1'b1;
          end else if (!cnz[t]) begin
            inv_hold[t] <= 1'b0;
          end
          // Follower held until completion table and store queue are empty.
          // Stores must have drained as well.
          if (next_dflush[t] && decode_req[t].after_inval) begin
            next_hold[t] <= 1'b1;
          end else if (!cnz[t] && store_reorder_queue_empty[t]) begin
            next_hold[t] <= 1'b0;
          end
          // Miss hold after a balance flush; setting wins over ending.
          // Resolve or threshold releases the thread.
          if (bal_sel[t]) begin
            miss_hold[t] <= 1'b1;
          end else if (mhold_end) begin
            miss_hold[t] <= 1'b0;
          end
          // Saturating per-thread miss counter.
          // Stopping at all ones means it never wraps.
          if (miss_resolved[t]) begin
            miss_cnt[t] <= '0;
          end else if ((bal_sel[t] || miss_hold[t]) && miss_cnt[t] != '1) begin
            miss_cnt[t] <= miss_cnt[t] + 4'h1;
          end
        end
      end
    end
  endgenerate

  assign completion_based_hold = miss_hold;
  assign decode_hold = pt_hold | inv_hold | next_hold | miss_hold;
  // A held thread drops out before priority is
  // applied, so priority can never pick it.
  // decode_request is the thread's own wish to
  // decode in this cycle.
  assign decode_eligible = decode_request & thread_active & ~decode_hold;

endmodule : sdf_flow_control

// ==== sdf_flow_monitor.sv ====
`timescale 1ns/1ns
module sdf_flow_monitor
  import sdf_pkg::*;
#(
  parameter int NTHR = 4
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [NTHR-1:0] thread_active,
  input wire logic [NTHR-1:0] dispatch_set,
  input wire sdf_decode_t [NTHR-1:0] decode_req,
  input wire sdf_stall_t [NTHR-1:0] stall_cause,
  input wire logic [NTHR-1:0] miss_pending,
  input wire logic [NTHR-1:0] decode_request,
  input wire logic [NTHR-1:0] dispatch_flush,
  input wire logic [NTHR-1:0] balance_flush,
  input wire logic [NTHR-1:0] dispatch_hold,
  input wire logic [NTHR-1:0] decode_hold,
  input wire logic [NTHR-1:0] completion_based_hold,
  input wire logic [NTHR-1:0] decode_eligible
);
  logic [1:0] mode_q;
  logic bal_off;
  logic share0;
  logic flush_ok;
  // Shadow copies of the mode and balance-disable bits, taken at the APB write edge.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= 2'h0;
      bal_off <= 1'b0;
    end else if (psel && penable && pwrite && paddr == SDF_MODE_OFS) begin
      mode_q <= pwdata[1:0];
    end else if (psel && penable && pwrite && paddr == SDF_THREAD_SWITCH_CONTROL_REG_OFS) begin
      bal_off <= pwdata[SDF_BAL_DIS_BIT];
    end
  end
  // Thread 0 shares its dispatch group with another active thread; flush_ok adds a nonzero mode code and no decode hold.
  assign share0 = thread_active[0] && |(thread_active[NTHR-1:1] & ~(dispatch_set[NTHR-1:1] ^ {(NTHR-1){dispatch_set[0]}}));
  assign flush_ok = (mode_q != 2'h0) && share0 && !decode_hold[0];
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  chk_single_quiet: assert property (mode_q == 2'h0 |=> dispatch_flush == '0)
    else $error("dispatch flush in single mode");
  chk_one_active: assert property ($countones(thread_active) <= 1 |=> dispatch_flush == '0)
    else $error("dispatch flush with one thread");
  chk_share_needed: assert property (mode_q != 2'h0 && !share0 |=> !dispatch_flush[0])
    else $error("dispatch flush without sharing");
  chk_ptesync_flush: assert property (flush_ok && decode_req[0].ptesync |=> dispatch_flush[0])
    else $error("page sync not flushed");
  chk_score_flush: assert property (flush_ok && decode_req[0].scoreboard |=> dispatch_flush[0])
    else $error("scoreboard not flushed");
  chk_serial_flush: assert property (flush_ok && decode_req[0].serialize |=> dispatch_flush[0])
    else $error("serializing not flushed");
  chk_stall_hold: assert property (dispatch_hold[0] == (thread_active[0] && (|stall_cause[0])))
    else $error("stall hold wrong");
  chk_hold_gate: assert property (decode_eligible == (decode_request & thread_active & ~decode_hold))
    else $error("held thread eligible");
  chk_bal_off: assert property (bal_off |=> balance_flush == '0)
    else $error("balance flush while disabled");
  chk_two_pair: assert property (mode_q == 2'h1 |=> $countones(balance_flush) <= 1)
    else $error("two balance flushes in two-thread mode");
  chk_hold_cause: assert property ($rose(decode_hold[0]) |-> dispatch_flush[0] || balance_flush[0])
    else $error("decode hold without flush");
  chk_clb_cause: assert property ($rose(completion_based_hold[0]) |-> balance_flush[0])
    else $error("completion hold without balance");
  chk_bal_miss: assert property (balance_flush[0] |-> $past(miss_pending[0]))
    else $error("balance flush without miss");
endmodule : sdf_flow_monitor

bind sdf_flow_control sdf_flow_monitor #(.NTHR(NTHR)) i_sdf_flow_monitor (
  .core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .thread_active, .dispatch_set, .decode_req,
  .stall_cause, .miss_pending, .decode_request, .dispatch_flush, .balance_flush, .dispatch_hold, .decode_hold,
  .completion_based_hold, .decode_eligible
);

// ==== sdf_core_model.sv ====
`timescale 1ns/1ns
module sdf_core_model
  import sdf_pkg::*;
#(
  parameter int NTHR = 4,
  parameter int CW = 6,
  parameter int RES_LAT = 20
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [NTHR-1:0] busy,
  input wire logic [NTHR-1:0] miss_pending,
  input wire logic [NTHR-1:0] balance_flush,
  output logic [NTHR-1:0][CW-1:0] completion_count,
  output logic [NTHR-1:0] miss_resolved,
  output logic [NTHR-1:0] drained
);
  logic [NTHR-1:0][7:0] miss_age;
  // Table entries fill while a thread is busy and retire one a cycle otherwise.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      completion_count <= '0;
      miss_age <= '0;
    end else begin
      for (int t = 0; t < NTHR; t++) begin
        if (balance_flush[t] && completion_count[t] != '0) begin
          completion_count[t] <= CW'(1); // Only the oldest group survives.
        end else if (busy[t] && completion_count[t] != '1) begin
          completion_count[t] <= completion_count[t] + CW'(1);
        end else if (!busy[t] && completion_count[t] != '0) begin
          completion_count[t] <= completion_count[t] - CW'(1);
        end
        miss_age[t] <= miss_pending[t] ? miss_age[t] + 8'h01 : 8'h00;
      end
    end
  end
  // Table and store queue read empty together; a miss resolves at a fixed age.
  always_comb begin
    for (int t = 0; t < NTHR; t++) begin
      drained[t] = (completion_count[t] == '0);
      miss_resolved[t] = miss_pending[t] && (miss_age[t] == 8'(RES_LAT));
    end
  end
endmodule : sdf_core_model

// ==== sdf_flow_control_tb_top.sv ====
`timescale 1ns/1ns
module sdf_flow_control_tb_top;
  import sdf_pkg::*;
  typedef struct packed {
    logic [1:0] mode;
    logic [3:0] active;
    logic [3:0] set;
    sdf_decode_t req;
    logic [3:0] flush;
  } sdf_row_t;
  logic core_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, dispatch_buffer_empty = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err;
  logic [3:0] thread_active = 4'h0, dispatch_set = 4'h0, busy = 4'h0, miss_pending = 4'h0, decode_request = 4'hF;
  sdf_decode_t [3:0] decode_req = '0;
  sdf_stall_t [3:0] stall_cause = '0;
  logic [3:0][5:0] completion_count;
  logic [3:0] miss_resolved, drained, dispatch_flush, balance_flush, dispatch_hold, decode_hold;
  logic [3:0] completion_based_hold, decode_eligible, seen, seen_hold, seen_df;
  int errors = 0;
  int check_count = 0;
  sdf_row_t rows [8] = '{'{2'h1, 4'h3, 4'h0, 6'h20, 4'h1}, '{2'h1, 4'h3, 4'h2, 6'h20, 4'h0},
    '{2'h0, 4'h3, 4'h0, 6'h20, 4'h0}, '{2'h2, 4'h1, 4'h0, 6'h04, 4'h0}, '{2'h2, 4'h5, 4'h0, 6'h04, 4'h1},
    '{2'h1, 4'h3, 4'h0, 6'h02, 4'h1}, '{2'h1, 4'h3, 4'h0, 6'h05, 4'h1}, '{2'h1, 4'h3, 4'h0, 6'h10, 4'h0}};
  sdf_flow_control i_sdf_flow_control (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .thread_active, .dispatch_set, .decode_req, .stall_cause, .completion_count,
    .inval_ack(drained), .store_reorder_queue_empty(drained), .ptesync_ready(drained), .miss_pending,
    .miss_resolved, .dispatch_buffer_empty, .decode_request, .dispatch_flush, .balance_flush, .dispatch_hold,
    .decode_hold, .completion_based_hold, .decode_eligible);
  sdf_core_model i_sdf_core_model (.core_clk, .nrst, .busy, .miss_pending, .balance_flush, .completion_count,
    .miss_resolved, .drained);
  // Free-running core clock.
  always #50 core_clk = ~core_clk;
  // Comparison, verdict and APB transfer helpers.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, got, exp);
    end
  endtask : chk
  task test_done;
    if (errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  task apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Balance run: thread 1 stalls while the given threads miss; flushes and holds are collected.
  task bal(input logic [1:0] mode, input logic [31:0] ctrl, input logic [3:0] miss, input logic [3:0] exp);
    apb(1'b1, SDF_THREAD_SWITCH_CONTROL_REG_OFS, ctrl);
    apb(1'b1, SDF_MODE_OFS, {30'h0, mode});
    @(posedge core_clk);
    thread_active <= 4'h3;
    busy <= 4'h3;
    repeat (8) @(posedge core_clk);
    miss_pending <= miss;
    stall_cause[1] <= 3'h1;
    seen = 4'h0;
    seen_hold = 4'h0;
    seen_df = 4'h0;
    repeat (30) begin
      @(posedge core_clk);
      #1;
      seen = seen | balance_flush;
      seen_df = seen_df | dispatch_flush;
      seen_hold = seen_hold | completion_based_hold;
    end
    chk({28'h0, seen}, {28'h0, exp});
    chk({28'h0, seen_hold}, {28'h0, exp});
    chk({28'h0, dispatch_hold}, 32'h2);
    chk({28'h0, seen_df}, ctrl[SDF_BAL_DISP_BIT] ? {28'h0, exp & 4'h2} : 32'h0);
    @(posedge core_clk);
    miss_pending <= 4'h0;
    busy <= 4'h0;
    stall_cause <= '0;
    repeat (20) @(posedge core_clk);
    #1;
    chk({28'h0, completion_based_hold}, 32'h0);
  endtask : bal
  // Main sequence: registers, flush table, invalidate drain, balance cases, reset.
  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    apb(1'b0, SDF_THREAD_SWITCH_CONTROL_REG_OFS, 32'h0);
    chk(rd, SDF_CTRL_RST);
    apb(1'b0, 12'h010, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, SDF_THREAD_SWITCH_CONTROL_REG_OFS, 32'h0001_0308);
    apb(1'b0, SDF_THREAD_SWITCH_CONTROL_REG_OFS, 32'h0);
    chk(rd, 32'h0001_0308);
    foreach (rows[i]) begin
      apb(1'b1, SDF_MODE_OFS, {30'h0, rows[i].mode});
      @(posedge core_clk);
      thread_active <= rows[i].active;
      dispatch_set <= rows[i].set;
      decode_req[0] <= rows[i].req;
      seen = 4'h0;
      repeat (2) begin
        @(posedge core_clk);
        #1;
        seen = seen | dispatch_flush;
      end
      chk({28'h0, seen}, {28'h0, rows[i].flush});
      @(posedge core_clk);
      decode_req[0] <= 6'h00;
      repeat (8) @(posedge core_clk);
    end
    busy <= 4'h1;
    repeat (10) @(posedge core_clk);
    decode_req[0] <= 6'h10;
    busy <= 4'h0;
    seen = 4'h0;
    repeat (2) begin
      @(posedge core_clk);
      #1;
      seen = seen | (dispatch_flush & decode_hold);
    end
    chk({28'h0, seen}, 32'h1);
    for (int n = 0; decode_hold[0] !== 1'b0; n++) begin
      if (n == 40) begin
        errors++;
        test_done();
      end
      @(posedge core_clk);
      #1;
    end
    @(posedge core_clk);
    decode_req[0] <= 6'h00;
    bal(2'h2, 32'h0, 4'h1, 4'h1);
    bal(2'h2, 32'h0, 4'h3, 4'h3);
    bal(2'h1, 32'h0, 4'h3, 4'h0);
    bal(2'h2, 32'h4, 4'h1, 4'h0);
    bal(2'h2, 32'h8, 4'h2, 4'h2);
    @(posedge core_clk);
    busy <= 4'h1;
    miss_pending <= 4'h1;
    stall_cause[1] <= 3'h1;
    nrst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({16'h0, dispatch_flush, balance_flush, decode_hold, completion_based_hold}, 32'h0);
    @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    apb(1'b0, SDF_MODE_OFS, 32'h0);
    chk(rd, SDF_MODE_RST);
    test_done();
  end
endmodule : sdf_flow_control_tb_top
